/* src/hpp_pkg.sv */
// Package: constants and types for the hub port power and strap control block
package hpp_pkg;
   localparam int NUM_PORTS = 4;
   // Strap pair code that disables a port (pair = {dplus, dminus})
   localparam logic [1:0] DIS_PAIR_CODE = 2'h3;
   // Power pin settle time after re-enable, before overcurrent is sensed
   localparam int SETTLE_NS = 1000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 8;
   // Overcurrent sense is active low on the shared pin
   localparam logic OC_ACTIVE = 1'b0;
   localparam logic [3:0] PORT_RST = 4'h0;
   localparam logic [1:0] SYNC_RST = 2'h0;
   localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES);
   localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 8'h00;

   typedef enum logic [2:0] {
      HPP_OFF    = 3'b001,
      HPP_SETTLE = 3'b010,
      HPP_ON     = 3'b100
   } hpp_state_t;
endpackage

/* src/hpp_port_ctl.sv */
// One downstream port: shared power-enable / overcurrent-sense pin control
`timescale 1ns/1ps
`default_nettype none
module hpp_port_ctl (
   input  wire logic CORE_CLK,
   input  wire logic RST,
   input  wire logic enable_req,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      powered,
   output logic      oc_event
);
   import hpp_pkg::*;
   typedef struct packed {
      hpp_state_t            state;
      logic [SETTLE_W-1:0]   cnt;
      logic                  oc;
   } hpp_port_t;

   hpp_port_t cur;
   hpp_port_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.oc = 1'b0;
      case (cur.state)
         HPP_OFF: begin
            if (enable_req) begin
               next_cur.state = HPP_SETTLE;
               next_cur.cnt = SETTLE_LOAD;
            end
         end
         HPP_SETTLE: begin
            // Pin is driven high here; monitor cannot be sensed yet
            if (!enable_req) begin
               next_cur.state = HPP_OFF;
            end else if (cur.cnt == SETTLE_ZERO) begin
               next_cur.state = HPP_ON;
            end else begin
               next_cur.cnt = cur.cnt - 8'h01;
            end
         end
         HPP_ON: begin
            if (pin_in == OC_ACTIVE) begin
               next_cur.oc = 1'b1;
               next_cur.state = HPP_OFF;
            end else if (!enable_req) begin
               next_cur.state = HPP_OFF;
            end
         end
         default: begin
            next_cur.state = HPP_OFF;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cur.state <= HPP_OFF;
         cur.cnt   <= SETTLE_ZERO;
         cur.oc    <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // High while enabling; released to sense the monitor when on.
   // Driven low when off, since the pin pull-up alone would power the port.
   assign pin_out  = (cur.state == HPP_SETTLE);
   assign pin_oe   = (cur.state != HPP_ON);
   assign powered  = (cur.state != HPP_OFF);
   assign oc_event = cur.oc;
endmodule
`default_nettype wire

/* src/hpp_top.sv */
// Top: strap capture, port disable, power control and upstream power detect
// What this block does
// - Capture straps at reset and external-reset rise
// - Strap pair per port selects port disable
// - Upstream power detect level is bus power
// - Detect toggle renegotiates without chip reset
// - Drive control pin high enables port power
`timescale 1ns/1ps
`default_nettype none
module hpp_top (
   input  wire logic                          CORE_CLK,
   input  wire logic                          RST,
   input  wire logic                          EXT_RESET_N,
   input  wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_DPLUS_DISABLE_STRAP,
   input  wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_DMINUS_DISABLE_STRAP,
   input  wire logic                          UPSTREAM_POWER_DETECT,
   input  wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_REQ,
   input  wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_IN,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_OUT,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_OE,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_DISABLED,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_POWERED,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_OC_STATUS,
   output logic      [hpp_pkg::NUM_PORTS-1:0] PORT_OC_EVENT,
   output logic                               UPSTREAM_POWER,
   output logic                               RENEGOTIATE
);
   import hpp_pkg::*;

   typedef struct packed {
      logic                 ext_rst_d;
      logic                 capture_pend;
      logic [NUM_PORTS-1:0] strap_dp;
      logic [NUM_PORTS-1:0] strap_dm;
      logic                 vbus;
      logic                 reneg;
      logic [NUM_PORTS-1:0] oc_status;
   } hpp_top_t;

   hpp_top_t cur;
   hpp_top_t next_cur;
   logic [NUM_PORTS-1:0] oc_pulse;
   logic [NUM_PORTS-1:0] pwr;
   logic [NUM_PORTS-1:0] disabled;

   function automatic logic pair_disables(input logic dp, input logic dm);
      pair_disables = ({dp, dm} == DIS_PAIR_CODE);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cur = cur;
      next_cur.ext_rst_d = EXT_RESET_N;
      next_cur.capture_pend = 1'b0;
      // Capture on the rising edge of external reset
      if (cur.capture_pend || (EXT_RESET_N && !cur.ext_rst_d)) begin
         next_cur.strap_dp = PORT_DPLUS_DISABLE_STRAP;
         next_cur.strap_dm = PORT_DMINUS_DISABLE_STRAP;
      end
      next_cur.vbus = UPSTREAM_POWER_DETECT;
      // Any change re-runs connection handling; straps are kept.
      // Reset already restarts everything, so the first edge gives no pulse.
      next_cur.reneg = (UPSTREAM_POWER_DETECT != cur.vbus) && !cur.capture_pend;
      // Set wins over the clear by power request drop
      next_cur.oc_status = (cur.oc_status & PORT_POWER_REQ) | oc_pulse;
   end

   // Power-on capture happens on the first edge after RST releases
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cur.ext_rst_d    <= 1'b0;
         cur.capture_pend <= 1'b1;
         cur.strap_dp     <= PORT_RST;
         cur.strap_dm     <= PORT_RST;
         cur.vbus         <= 1'b0;
         cur.reneg        <= 1'b0;
         cur.oc_status    <= PORT_RST;
      end else begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   generate
      for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
         assign disabled[i] = pair_disables(cur.strap_dp[i], cur.strap_dm[i]);
         hpp_port_ctl u_port (
            .CORE_CLK   (CORE_CLK),
            .RST        (RST),
            // Held off while in external reset, disabled or tripped; the event
            // term covers the one cycle before the sticky status is set
            .enable_req (PORT_POWER_REQ[i] && !disabled[i] && cur.ext_rst_d
                         && !cur.oc_status[i] && !oc_pulse[i]),
            .pin_in     (PORT_POWER_CTL_IN[i]),
            .pin_out    (PORT_POWER_CTL_OUT[i]),
            .pin_oe     (PORT_POWER_CTL_OE[i]),
            .powered    (pwr[i]),
            .oc_event   (oc_pulse[i])
         );
      end
   endgenerate

   assign PORT_DISABLED  = disabled;
   assign PORT_POWERED   = pwr;
   assign PORT_OC_STATUS = cur.oc_status;
   assign PORT_OC_EVENT  = oc_pulse;
   assign UPSTREAM_POWER = cur.vbus;
   assign RENEGOTIATE    = cur.reneg;
endmodule
`default_nettype wire

/* sim/hpp_top_chk.sv */
// Checker: port power, strap and detect relations
`timescale 1ns/1ps
`default_nettype none
module hpp_top_chk (
   input wire logic                          CORE_CLK,
   input wire logic                          RST,
   input wire logic                          EXT_RESET_N,
   input wire logic                          UPSTREAM_POWER_DETECT,
   input wire logic                          UPSTREAM_POWER,
   input wire logic                          RENEGOTIATE,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_DPLUS_DISABLE_STRAP,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_DMINUS_DISABLE_STRAP,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_IN,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_OUT,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_CTL_OE,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_DISABLED,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWERED,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_OC_STATUS,
   input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_OC_EVENT
);
   import hpp_pkg::*;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire [NUM_PORTS-1:0] pair = PORT_DPLUS_DISABLE_STRAP & PORT_DMINUS_DISABLE_STRAP;
   wire [NUM_PORTS-1:0] trip = PORT_POWERED & ~PORT_POWER_CTL_OE & ~PORT_POWER_CTL_IN;
   logic [7:0] oe_run;
   // Cycles the pin is driven high; only port 0 is timed, to keep helper logic small
   always_ff @(posedge CORE_CLK)
      oe_run <= (PORT_POWER_CTL_OE[0] && PORT_POWER_CTL_OUT[0]) ? oe_run + 8'h01 : 8'h00;
   sequence s_settled;
      $fell(PORT_POWER_CTL_OE[0]) && PORT_POWERED[0];
   endsequence
   sequence s_toggle;
      !$past(RST) && $changed(UPSTREAM_POWER_DETECT) ##1 $stable(UPSTREAM_POWER_DETECT);
   endsequence
   sequence s_reneg_once;
      RENEGOTIATE ##1 !RENEGOTIATE;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_pin_drive_high: assert property ((PORT_POWER_CTL_OE & PORT_POWER_CTL_OUT)
      == (PORT_POWER_CTL_OE & PORT_POWERED)) else $error("pin drive level wrong");
   a_off_drive_low: assert property ((PORT_POWER_CTL_OE | PORT_POWERED) == 4'hf)
      else $error("unpowered pin released");
   a_settle_span: assert property (s_settled |-> oe_run == SETTLE_CYCLES + 1)
      else $error("settle span wrong");
   a_strap_hold: assert property (EXT_RESET_N && $past(EXT_RESET_N) && $past(EXT_RESET_N, 2)
      && $past(EXT_RESET_N, 3) && !$past(RST) && !$past(RST, 2) && !$past(RST, 3) |-> $stable(PORT_DISABLED))
      else $error("straps moved");
   a_pair_disable: assert property ($rose(EXT_RESET_N) |-> ##2 PORT_DISABLED == $past(pair, 2))
      else $error("disable pair wrong");
   a_detect_level: assert property ($stable(UPSTREAM_POWER_DETECT) [*5] |->
      UPSTREAM_POWER == UPSTREAM_POWER_DETECT) else $error("detect level lost");
   a_reneg_pulse: assert property (s_toggle |-> s_reneg_once)
      else $error("no renegotiation");
   a_reneg_keeps: assert property ($rose(RENEGOTIATE) |-> $stable(PORT_POWERED))
      else $error("power lost on renegotiation");
   a_oc_event: assert property (!$past(RST) |-> PORT_OC_EVENT == $past(trip)
      && (PORT_OC_EVENT & PORT_POWERED) == 4'h0) else $error("overcurrent wrong");
   a_oc_sticky: assert property (!$past(RST) |-> ($past(PORT_OC_EVENT) & ~PORT_OC_STATUS) == 4'h0)
      else $error("overcurrent status not set");
endmodule
bind hpp_top hpp_top_chk i_hpp_top_chk (.CORE_CLK, .RST, .EXT_RESET_N, .UPSTREAM_POWER_DETECT,
   .UPSTREAM_POWER, .RENEGOTIATE, .PORT_DPLUS_DISABLE_STRAP, .PORT_DMINUS_DISABLE_STRAP, .PORT_POWER_CTL_IN,
   .PORT_POWER_CTL_OUT, .PORT_POWER_CTL_OE, .PORT_DISABLED, .PORT_POWERED, .PORT_OC_STATUS, .PORT_OC_EVENT);
`default_nettype wire

/* sim/hpp_monitor.sv */
// Current monitors and pull-ups on the shared power pins
`timescale 1ns/1ps
`default_nettype none
module hpp_monitor (
   input  wire logic [3:0] oe,
   input  wire logic [3:0] drv,
   input  wire logic [3:0] oc,
   output logic      [3:0] pin
);
   // Pull-up wins when nobody drives and no trip
   assign pin = (oe & drv) | (~oe & ~oc);
endmodule
`default_nettype wire

/* sim/hpp_top_test.sv */
// Testbench for the port power and strap block
`timescale 1ns/1ps
`default_nettype none
module hpp_top_test;
   logic clk = 0, rst = 1, ext_n = 1, det = 1, up, ren;
   logic [3:0] dp = 4'h5, dm = 4'h3, req = 4'h0, oc = 4'h0;
   logic [3:0] pin, out, oe, dis, pwr, ocs, oce;
   int n_errors = 0, checked = 0;
   always #4 clk = ~clk;
   hpp_top i_hpp_top (.CORE_CLK(clk), .RST(rst), .EXT_RESET_N(ext_n), .PORT_DPLUS_DISABLE_STRAP(dp),
      .PORT_DMINUS_DISABLE_STRAP(dm), .UPSTREAM_POWER_DETECT(det), .PORT_POWER_REQ(req), .PORT_POWER_CTL_IN(pin),
      .PORT_POWER_CTL_OUT(out), .PORT_POWER_CTL_OE(oe), .PORT_DISABLED(dis), .PORT_POWERED(pwr),
      .PORT_OC_STATUS(ocs), .PORT_OC_EVENT(oce), .UPSTREAM_POWER(up), .RENEGOTIATE(ren));
   hpp_monitor i_hpp_monitor (.oe(oe), .drv(out), .oc(oc), .pin(pin));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [3:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic summarize;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      summarize;
   end
   initial begin
      cyc(20);
      rst = 0;
      cyc(4);
      chk(dis, 4'h1);
      dp = 4'hf;
      dm = 4'h6;
      cyc(3);
      chk(dis, 4'h1);
      ext_n = 0;
      cyc(2);
      ext_n = 1;
      cyc(4);
      chk(dis, 4'h6);
      $display("strap test done");
      req = 4'hf;
      cyc(3);
      chk(oe, 4'hf);
      chk(out, 4'h9);
      chk(pin, 4'h9);
      chk(pwr, 4'h9);
      cyc(123);
      chk(oe, 4'hf);
      cyc(1);
      chk(oe, 4'h6);
      chk(pin, 4'h9);
      oc = 4'h1;
      cyc(1);
      chk(oce, 4'h1);
      chk(pwr, 4'h8);
      chk(ocs, 4'h0);
      cyc(1);
      chk(oce, 4'h0);
      chk(ocs, 4'h1);
      chk(pwr, 4'h8);
      chk(oe, 4'h7);
      oc = 4'h0;
      cyc(3);
      chk(pwr, 4'h8);
      req = 4'he;
      cyc(2);
      chk(ocs, 4'h0);
      req = 4'hf;
      cyc(2);
      chk(pwr, 4'h9);
      $display("power test done");
      det = 0;
      cyc(1);
      chk({3'h0, ren}, 4'h1);
      cyc(1);
      chk({3'h0, ren}, 4'h0);
      cyc(6);
      chk({3'h0, up}, 4'h0);
      chk(pwr, 4'h9);
      chk(dis, 4'h6);
      det = 1;
      cyc(8);
      chk({3'h0, up}, 4'h1);
      $display("detect test done");
      summarize;
   end
endmodule
`default_nettype wire
